/* File: tws_master.sv */
// byte-level two-wire serial master with a two-entry receive buffer
`timescale 1ns/1ps
`default_nettype none

module tws_master (
  // clock, reset, clock enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  // configuration
  input wire logic enable,
  input wire logic [15:0] prescale,
  input wire logic irq_en,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic cmd_ack,
  input wire logic [7:0] tx_byte,
  // status
  input wire logic done_clr,
  output logic done_flag,
  output logic irq,
  output logic tip,
  output logic rx_ack,
  output logic bus_busy,
  // received bytes
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  // bus pins
  input wire logic serial_clock_line_i,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe
);
  tws_pkg::tws_regs_t regs_ff;
  tws_pkg::tws_regs_t nxt_regs;
  logic scl_hi;
  logic sda_hi;
  logic tick;
  logic push;
  logic pop;
  logic finish;

  function automatic logic [1:0] bump(input logic [1:0] c,
                                      input logic up,
                                      input logic down);
    bump = c + {1'b0, up} - {1'b0, down};
  endfunction

  assign scl_hi = regs_ff.sync2[tws_pkg::LN_SCL];
  assign sda_hi = regs_ff.sync2[tws_pkg::LN_SDA];
  assign tick = (regs_ff.tmr == 16'h0000);
  assign pop = rx_valid && rx_ready;
  assign cmd_ready = enable && regs_ff.state == tws_pkg::ST_IDLE &&
                     regs_ff.cnt != tws_pkg::RXBUF_FULL;

  always_comb begin
    nxt_regs = regs_ff;
    push = 1'b0;
    finish = 1'b0;
    nxt_regs.sync1 = {serial_clock_line_i, serial_data_line_i};
    nxt_regs.sync2 = regs_ff.sync1;
    nxt_regs.prev = regs_ff.sync2;
    nxt_regs.irq = 1'b0;
    // start by anyone: data falls with clock high; stop: data rises
    if (regs_ff.prev[tws_pkg::LN_SCL] && scl_hi &&
        regs_ff.prev[tws_pkg::LN_SDA] && !sda_hi) begin
      nxt_regs.busy = 1'b1;
    end else if (regs_ff.prev[tws_pkg::LN_SCL] && scl_hi &&
                 !regs_ff.prev[tws_pkg::LN_SDA] && sda_hi) begin
      nxt_regs.busy = 1'b0;
    end
    if (done_clr) begin
      nxt_regs.done = 1'b0;
    end
    if (!tick) begin
      nxt_regs.tmr = regs_ff.tmr - 16'h0001;
    end
    unique case (regs_ff.state)
      tws_pkg::ST_IDLE: begin
        // only own commands move the lines: no slave behaviour
        if (cmd_valid && cmd_ready) begin
          nxt_regs.c_sta = cmd_start;
          nxt_regs.c_sto = cmd_stop;
          nxt_regs.c_rd = cmd_read;
          nxt_regs.c_wr = cmd_write;
          nxt_regs.c_ack = cmd_ack;
          nxt_regs.sh = tx_byte;
          nxt_regs.bitn = 4'h0;
          nxt_regs.ph = 2'h0;
          nxt_regs.tmr = prescale;
          nxt_regs.tip = 1'b1;
          if (cmd_start) begin
            nxt_regs.state = tws_pkg::ST_START;
          end else if (cmd_read || cmd_write) begin
            nxt_regs.state = tws_pkg::ST_BIT;
          end else if (cmd_stop) begin
            nxt_regs.state = tws_pkg::ST_STOP;
          end else begin
            finish = 1'b1;
          end
        end
      end
      tws_pkg::ST_START: begin
        unique case (regs_ff.ph)
          2'h0: begin
            // release both lines, also for a repeated start
            nxt_regs.sda_oe = 1'b0;
            nxt_regs.scl_oe = 1'b0;
            if (tick) begin
              nxt_regs.ph = 2'h1;
              nxt_regs.tmr = prescale;
            end
          end
          2'h1: begin
            if (!scl_hi) begin
              nxt_regs.tmr = prescale;
            end else if (tick) begin
              nxt_regs.sda_oe = 1'b1;
              nxt_regs.ph = 2'h2;
              nxt_regs.tmr = prescale;
            end
          end
          default: begin
            if (tick) begin
              nxt_regs.scl_oe = 1'b1;
              nxt_regs.ph = 2'h0;
              nxt_regs.tmr = prescale;
              nxt_regs.state = (regs_ff.c_rd || regs_ff.c_wr) ?
                               tws_pkg::ST_BIT : tws_pkg::ST_STOP;
            end
          end
        endcase
      end
      tws_pkg::ST_BIT: begin
        if (regs_ff.ph == 2'h0) begin
          nxt_regs.scl_oe = 1'b1;
          if (regs_ff.bitn != tws_pkg::ACK_SLOT) begin
            nxt_regs.sda_oe = regs_ff.c_wr && !regs_ff.sh[7];
          end else begin
            nxt_regs.sda_oe = regs_ff.c_rd && !regs_ff.c_ack;
          end
          if (tick) begin
            nxt_regs.ph = 2'h1;
            nxt_regs.tmr = prescale;
          end
        end else begin
          nxt_regs.scl_oe = 1'b0;
          if (!scl_hi) begin
            nxt_regs.tmr = prescale;
          end else if (tick) begin
            nxt_regs.scl_oe = 1'b1;
            nxt_regs.ph = 2'h0;
            nxt_regs.tmr = prescale;
            if (regs_ff.bitn != tws_pkg::ACK_SLOT) begin
              nxt_regs.sh = {regs_ff.sh[6:0], sda_hi};
              nxt_regs.bitn = regs_ff.bitn + 4'h1;
            end else begin
              nxt_regs.rx_ack = sda_hi;
              push = regs_ff.c_rd;
              if (regs_ff.c_sto) begin
                nxt_regs.state = tws_pkg::ST_STOP;
              end else begin
                finish = 1'b1;
              end
            end
          end
        end
      end
      tws_pkg::ST_STOP: begin
        unique case (regs_ff.ph)
          2'h0: begin
            nxt_regs.scl_oe = 1'b1;
            nxt_regs.sda_oe = 1'b1;
            if (tick) begin
              nxt_regs.ph = 2'h1;
              nxt_regs.tmr = prescale;
            end
          end
          2'h1: begin
            nxt_regs.scl_oe = 1'b0;
            if (!scl_hi) begin
              nxt_regs.tmr = prescale;
            end else if (tick) begin
              nxt_regs.ph = 2'h2;
              nxt_regs.tmr = prescale;
            end
          end
          default: begin
            nxt_regs.sda_oe = 1'b0;
            if (tick) begin
              finish = 1'b1;
            end
          end
        endcase
      end
      default: begin
        nxt_regs.state = tws_pkg::ST_IDLE;
      end
    endcase
    if (push) begin
      nxt_regs.mem[regs_ff.wp] = nxt_regs.sh;
      nxt_regs.wp = !regs_ff.wp;
    end
    if (pop) begin
      nxt_regs.rp = !regs_ff.rp;
    end
    nxt_regs.cnt = bump(regs_ff.cnt, push, pop);
    if (finish) begin
      nxt_regs.state = tws_pkg::ST_IDLE;
      nxt_regs.tip = 1'b0;
      nxt_regs.c_sta = 1'b0;
      nxt_regs.c_sto = 1'b0;
      nxt_regs.c_rd = 1'b0;
      nxt_regs.c_wr = 1'b0;
      nxt_regs.c_ack = 1'b0;
      nxt_regs.done = 1'b1;
      nxt_regs.irq = irq_en;
    end
    // disabled: give the pins back and abandon any transfer
    if (!enable) begin
      nxt_regs.scl_oe = 1'b0;
      nxt_regs.sda_oe = 1'b0;
      nxt_regs.state = tws_pkg::ST_IDLE;
      nxt_regs.tip = 1'b0;
      nxt_regs.ph = 2'h0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regs_ff <= tws_pkg::REGS_RST;
    end else if (ce) begin
      regs_ff <= nxt_regs;
    end
  end

  // lines are only ever pulled low
  assign serial_clock_line_o = 1'b0;
  assign serial_data_line_o = 1'b0;
  assign serial_clock_line_oe = regs_ff.scl_oe;
  assign serial_data_line_oe = regs_ff.sda_oe;
  assign done_flag = regs_ff.done;
  assign irq = regs_ff.irq;
  assign tip = regs_ff.tip;
  assign rx_ack = regs_ff.rx_ack;
  assign bus_busy = regs_ff.busy;
  assign rx_valid = regs_ff.cnt != 2'h0;
  assign rx_data = regs_ff.mem[regs_ff.rp];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  chk_disabled_released: assert property (
    (ce && !enable) |=> (!serial_clock_line_oe && !serial_data_line_oe))
    else $error("pins driven while disabled");
  chk_stretch_waits: assert property (
    (ce && enable && regs_ff.state == tws_pkg::ST_BIT &&
     regs_ff.ph == 2'h1 && !scl_hi) |=> (regs_ff.ph == 2'h1))
    else $error("high phase ended while clock held low");
  chk_low_phase_len: assert property (
    (ce && enable && regs_ff.state == tws_pkg::ST_BIT &&
     regs_ff.ph == 2'h0 && regs_ff.tmr != 16'h0000) |=>
    (regs_ff.ph == 2'h0 && serial_clock_line_oe))
    else $error("low phase shorter than prescale");
  chk_write_msb: assert property (
    (regs_ff.state == tws_pkg::ST_BIT && regs_ff.ph == 2'h1 &&
     regs_ff.c_wr && regs_ff.bitn != tws_pkg::ACK_SLOT) |->
    (serial_data_line_oe == !regs_ff.sh[7]))
    else $error("written bit is not shift msb");
  chk_ack_level: assert property (
    (regs_ff.state == tws_pkg::ST_BIT && regs_ff.ph == 2'h1 &&
     regs_ff.c_rd && regs_ff.bitn == tws_pkg::ACK_SLOT) |->
    (serial_data_line_oe == !regs_ff.c_ack))
    else $error("read acknowledge level wrong");
  chk_read_pushed: assert property (
    (ce && push && !pop) |=> (regs_ff.cnt == $past(regs_ff.cnt) + 2'h1))
    else $error("read byte not buffered");
  chk_finish_clears: assert property (
    (ce && enable && finish) |=>
    (!tip && done_flag && !regs_ff.c_rd && !regs_ff.c_wr &&
     irq == $past(irq_en)))
    else $error("finish left command state behind");
  chk_start_edge: assert property (
    (regs_ff.state == tws_pkg::ST_START && regs_ff.ph == 2'h2) |->
    (serial_data_line_oe && !serial_clock_line_oe))
    else $error("start edge without clock high");
  chk_busy_on_start: assert property (
    (ce && regs_ff.prev == 2'h3 && regs_ff.sync2 == 2'h2) |=> bus_busy)
    else $error("start seen but bus not busy");
  chk_idle_quiet: assert property (
    (ce && enable && regs_ff.state == tws_pkg::ST_IDLE && !cmd_valid) |=>
    $stable(serial_data_line_oe))
    else $error("data line moved without a command");

  cov_read_byte: cover property (ce && push && regs_ff.c_ack);
  cov_write_stop: cover property (
    ce && finish && regs_ff.state == tws_pkg::ST_STOP && regs_ff.c_wr);
  cov_stretch: cover property (
    regs_ff.state == tws_pkg::ST_BIT && regs_ff.ph == 2'h1 && !scl_hi);
  cov_buf_full: cover property (regs_ff.cnt == tws_pkg::RXBUF_FULL);
endmodule

`default_nettype wire

/* File: tws_pkg.sv */
// constants and types of the two-wire serial master
package tws_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // fastest bit rate that the prescaler must reach
  localparam int unsigned MAX_RATE_BPS = 400_000;
  // half-bit count for the fastest rate: each half lasts prescale + 1 cycles
  localparam logic [15:0] PRESCALE_MAX_RATE =
    16'((CLK_HZ / (2 * MAX_RATE_BPS)) - 1);
  localparam int unsigned PRESCALE_W = 16;
  localparam int unsigned BYTE_W = 8;
  // index of the acknowledge slot after eight data bits
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int unsigned RXBUF_DEPTH = 2;
  localparam logic [1:0] RXBUF_FULL = 2'h2;
  // bus line pair order inside sampled vectors
  localparam int unsigned LN_SCL = 1;
  localparam int unsigned LN_SDA = 0;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_BIT   = 5'h04,
    ST_STOP  = 5'h08,
    ST_SPARE = 5'h10
  } tws_state_t;

  typedef struct packed {
    tws_state_t state;
    logic [1:0] ph;
    logic [15:0] tmr;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic c_sta;
    logic c_sto;
    logic c_rd;
    logic c_wr;
    logic c_ack;
    logic scl_oe;
    logic sda_oe;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic busy;
    logic done;
    logic irq;
    logic rx_ack;
    logic tip;
    logic [1:0][7:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } tws_regs_t;

  localparam tws_regs_t REGS_RST = '{
    state: ST_IDLE, ph: 2'h0, tmr: 16'h0000, bitn: 4'h0, sh: 8'h00,
    c_sta: 1'b0, c_sto: 1'b0, c_rd: 1'b0, c_wr: 1'b0, c_ack: 1'b0,
    scl_oe: 1'b0, sda_oe: 1'b0, sync1: 2'h3, sync2: 2'h3, prev: 2'h3,
    busy: 1'b0, done: 1'b0, irq: 1'b0, rx_ack: 1'b0, tip: 1'b0,
    mem: 16'h0000, wp: 1'b0, rp: 1'b0, cnt: 2'h0};
endpackage

/* File: tws_slave_model.sv */
// behavioural slave on the two-wire bus, with clock stretching
`timescale 1ns/1ps
`default_nettype none
module tws_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // clock for stretch timing
  input wire logic clk,
  // resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // behaviour set by the bench
  input wire logic [3:0] stretch,
  input wire logic [7:0] rd_byte,
  // pull-downs and last byte written to us
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] got
);
  logic [7:0] sh, k, tx;
  logic first, sel, rd;
  int n;
  // read bytes count up from rd_byte
  assign tx = rd_byte + k;
  initial begin
    {scl_oe, sda_oe, first, sel, rd} = '0;
    {sh, k, got} = '0;
    n = 0;
  end
  always @(negedge sda) if (scl) begin
    n = 0;
    k = 0;
    first = 1;
    sel = 0;
  end
  always @(posedge sda) if (scl) {first, sel} = 2'b00;
  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    n++;
    if (n == 8 && first) {sel, rd} = {sh[7:1] == ADDR, sh[0]};
    else if (n == 8 && sel && !rd) got = sh;
    // a refused read byte ends our turn on the data line
    if (n == 9 && sel && rd && !first && sda) sel = 0;
  end
  always @(negedge scl) begin
    if (n == 9) begin
      if (!first && rd && sel) k++;
      n = 0;
      first = 0;
    end
    if (n == 8) sda_oe <= sel && (first || !rd);
    else sda_oe <= sel && rd && !first && !tx[7-n];
    if (stretch != 0) begin
      scl_oe = 1;
      repeat (stretch) @(posedge clk);
      scl_oe = 0;
    end
  end
endmodule
`default_nettype wire

/* File: tws_master_tb.sv */
// self-checking bench of the two-wire serial master with a slave model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tws_master_tb;
  localparam logic [6:0] ADDR = 7'h2a;
  logic core_clk, resetn, enable, irq_en, cmd_valid, done_clr, rx_ready;
  logic cmd_start, cmd_stop, cmd_read, cmd_write, cmd_ack;
  logic [15:0] prescale;
  logic [7:0] tx_byte, rd_byte, got, d, rx_data;
  logic [3:0] stretch;
  logic [3:0] frz;
  logic cmd_ready, done_flag, irq, tip, rx_ack, bus_busy, rx_valid;
  logic scl, sda, scl_o, sda_o, scl_oe, sda_oe, s_scl_oe, s_sda_oe;
  logic pscl, psda, ce;
  int failures, n_checks, starts, stops, irqs, exp_irq, hi, i;
  // wired-and with pull-up
  assign scl = !(scl_oe || s_scl_oe);
  assign sda = !(sda_oe || s_sda_oe);
  tws_master DUT (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .enable(enable), .prescale(prescale), .irq_en(irq_en),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_start(cmd_start),
    .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_write(cmd_write),
    .cmd_ack(cmd_ack), .tx_byte(tx_byte), .done_clr(done_clr),
    .done_flag(done_flag), .irq(irq), .tip(tip), .rx_ack(rx_ack),
    .bus_busy(bus_busy), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .serial_clock_line_i(scl),
    .serial_clock_line_o(scl_o), .serial_clock_line_oe(scl_oe),
    .serial_data_line_i(sda), .serial_data_line_o(sda_o),
    .serial_data_line_oe(sda_oe));
  tws_slave_model #(.ADDR(ADDR)) slave (.clk(core_clk), .scl(scl),
    .sda(sda), .stretch(stretch), .rd_byte(rd_byte), .scl_oe(s_scl_oe),
    .sda_oe(s_sda_oe), .got(got));
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (scl && pscl && psda && !sda) starts++;
    if (scl && pscl && !psda && sda) stops++;
    if (irq === 1'b1) irqs++;
    `CHK("pin_out", 2'b00, {scl_o, sda_o})
    if (scl && tip && enable) hi++;
    else begin
      if (hi != 0 && enable) `CHK("high_len", 1'b1, hi > prescale)
      hi = 0;
    end
    pscl <= scl;
    psda <= sda;
  end
  // each read byte counts up from the model's base value
  function automatic logic [7:0] exp_rx(input logic [7:0] base,
                                        input int k);
    exp_rx = 8'(base + k);
  endfunction
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(inout int t);
    @(negedge core_clk);
    t++;
    if (t > 20000) begin
      failures++;
      $display("BAD wait exp done got timeout");
      report_and_stop;
    end
  endtask
  // bits are start, stop, read, write, ack level
  task automatic run_cmd(input logic [4:0] bits, input logic [7:0] b);
    int t;
    t = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1) tick(t);
    {cmd_start, cmd_stop, cmd_read, cmd_write, cmd_ack} = bits;
    tx_byte = b;
    prescale = 16'(3 + $urandom_range(0, 3));
    irq_en = 1'($urandom);
    if (irq_en) exp_irq++;
    cmd_valid = 1;
    done_clr = 1;
    @(negedge core_clk);
    cmd_valid = 0;
    done_clr = 0;
    `CHK("tip_on", 1'b1, tip)
    `CHK("done_low", 1'b0, done_flag)
    while (done_flag !== 1'b1) tick(t);
    `CHK("tip_off", 1'b0, tip)
    repeat (4) @(negedge core_clk);
  endtask
  initial begin
    {resetn, enable, irq_en, cmd_valid, done_clr, rx_ready} = 6'b010000;
    {cmd_start, cmd_stop, cmd_read, cmd_write, cmd_ack} = '0;
    {prescale, tx_byte, rd_byte, stretch} = '0;
    {pscl, psda} = 2'b11;
    ce = 1;
    {failures, n_checks, starts, stops, irqs, exp_irq, hi} = '0;
    i = $urandom(32'h8a6a);
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1;
    `CHK("rst_oe", 2'b00, {scl_oe, sda_oe})
    `CHK("rst_flags", 3'b000, {done_flag, tip, bus_busy})
    `CHK("rst_rdy", 1'b1, cmd_ready)
    for (i = 0; i < 3; i++) begin
      stretch = (i == 1) ? 4'h6 : 4'h0;
      d = 8'($urandom);
      run_cmd(5'b10010, {ADDR, 1'b0});
      `CHK("addr_ack", 1'b0, rx_ack)
      `CHK("busy", 1'b1, bus_busy)
      run_cmd(5'b01010, d);
      `CHK("wr_byte", d, got)
      `CHK("free", 1'b0, bus_busy)
    end
    run_cmd(5'b11010, {~ADDR, 1'b0});
    `CHK("nack", 1'b1, rx_ack)
    rd_byte = 8'($urandom);
    run_cmd(5'b10010, {ADDR, 1'b1});
    run_cmd(5'b00100, 8'h00);
    `CHK("rd_ack", 1'b0, rx_ack)
    run_cmd(5'b01101, 8'h00);
    `CHK("rd_nack", 1'b1, rx_ack)
    `CHK("full", 1'b0, cmd_ready)
    for (i = 0; i < 2; i++) begin
      `CHK("rx", {1'b1, exp_rx(rd_byte, i)}, {rx_valid, rx_data})
      rx_ready = 1;
      @(negedge core_clk);
      rx_ready = 0;
    end
    `CHK("empty", 1'b0, rx_valid)
    `CHK("starts", 5, starts)
    `CHK("stops", 5, stops)
    `CHK("irqs", exp_irq, irqs)
    `CHK("idle_rdy", 1'b1, cmd_ready)
    {cmd_start, cmd_stop, cmd_read, cmd_write} = 4'b1001;
    cmd_valid = 1;
    @(negedge core_clk);
    cmd_valid = 0;
    repeat (30) @(negedge core_clk);
    // clock enable low must freeze the transfer mid-byte
    ce = 0;
    frz = {scl_oe, sda_oe, tip, bus_busy};
    repeat (12) @(negedge core_clk);
    `CHK("ce_hold", frz, {scl_oe, sda_oe, tip, bus_busy})
    ce = 1;
    repeat (5) @(negedge core_clk);
    enable = 0;
    @(negedge core_clk);
    `CHK("off_oe", 2'b00, {scl_oe, sda_oe})
    `CHK("off_rdy", 1'b0, cmd_ready)
    report_and_stop;
  end
endmodule
`default_nettype wire
